// file: rtl/smr_pkg.sv
// Constants, types and helpers shared by the polled-sensor register bank.
// Function
// - Per-device critical flag set above critical limit.
// - No-acknowledge mask bit suppresses that device's fault.
// - CRC-error mask bit suppresses that device's fault.
// - Timeout mask bit suppresses that device's fault.
// - Limit mask bit suppresses high/low limit faults.
// - Invalid-data mask bit suppresses that device's fault.
// - Masks and critical status reset to zero.
// - Shared unsigned high limit, reset 0x7f.
// - Shared signed low limit, reset 0x81.
// - Shared unsigned critical limit, reset 0x64.
// - Shared fan start temperature, reset 0x5a.
// - Four-bit span code decodes to 2..80 C.
// - Span/interval register resets 0x0c, bits 5:4 reserved.
// - Loop period 250/500/750/1000 ms from bits 7:6.
// - Per-device no-ack, CRC, timeout, limit, invalid flags.
// - Polling and fault detection only while enabled.
package smr_pkg;

    // ------------------------------------------------------------------
    // Register map.
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CRIT_STATUS = 8'hbb;
    localparam logic [7:0] ADDR_NOACK_MASK = 8'hbc;
    localparam logic [7:0] ADDR_CRC_MASK = 8'hbd;
    localparam logic [7:0] ADDR_TIMEOUT_MASK = 8'hbe;
    localparam logic [7:0] ADDR_LIMIT_MASK = 8'hbf;
    localparam logic [7:0] ADDR_INVALID_MASK = 8'hc0;
    localparam logic [7:0] ADDR_HIGH_LIMIT = 8'hc1;
    localparam logic [7:0] ADDR_LOW_LIMIT = 8'hc2;
    localparam logic [7:0] ADDR_CRIT_LIMIT = 8'hc3;
    localparam logic [7:0] ADDR_FAN_START = 8'hc6;
    localparam logic [7:0] ADDR_SPAN_INTERVAL = 8'hc7;

    // ------------------------------------------------------------------
    // Reset values and field positions.
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_STATUS_MASK = 8'h00;
    localparam logic [7:0] RST_HIGH_LIMIT = 8'h7f;
    localparam logic [7:0] RST_LOW_LIMIT = 8'h81;
    localparam logic [7:0] RST_CRIT_LIMIT = 8'h64;
    localparam logic [7:0] RST_FAN_START = 8'h5a;
    localparam logic [7:0] RST_SPAN_INTERVAL = 8'h0c;
    localparam int SPAN_LSB = 0;
    localparam int SPAN_MSB = 3;
    localparam int INTERVAL_LSB = 6;
    localparam int INTERVAL_MSB = 7;

    // ------------------------------------------------------------------
    // Timing: one loop unit of 250 ms at the 40 MHz clock.
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int POLL_UNIT_MS = 250;
    localparam int POLL_UNIT_CYCLES = CLK_HZ / 1000 * POLL_UNIT_MS;
    localparam int TICK_CNT_W = 24;
    localparam int NUM_DEV = 8;

    // Poll timer states.
    typedef enum logic [0:0] {
        POLL_IDLE = 1'b0,
        POLL_RUN = 1'b1
    } smr_poll_e;

    // Ramp span in hundredths of a degree for each span code.
    function automatic logic [13:0] smr_span_x100(input logic [3:0] code);
        logic [13:0] v;
        v = 14'h0000;
        case (code)
            4'h0: v = 14'd200;
            4'h1: v = 14'd250;
            4'h2: v = 14'd333;
            4'h3: v = 14'd400;
            4'h4: v = 14'd500;
            4'h5: v = 14'd667;
            4'h6: v = 14'd800;
            4'h7: v = 14'd1000;
            4'h8: v = 14'd1333;
            4'h9: v = 14'd1600;
            4'ha: v = 14'd2000;
            4'hb: v = 14'd2667;
            4'hc: v = 14'd3200;
            4'hd: v = 14'd4000;
            4'he: v = 14'd5333;
            default: v = 14'd8000;
        endcase
        return v;
    endfunction

endpackage

// file: rtl/smr_regs.sv
// Register bank, loop timer and fault flags of the polled-sensor master.
`timescale 1ns/10ps

module smr_regs
    import smr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = POLL_UNIT_CYCLES
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_RD_IN,
    output logic [7:0] REG_RDATA_OUT,
    input wire logic POLLER_ENABLE_IN,
    output logic POLL_START_OUT,
    input wire logic RESULT_VALID_IN,
    input wire logic [2:0] RESULT_DEV_IN,
    input wire logic [7:0] RESULT_TEMP_IN,
    input wire logic RESULT_NOACK_IN,
    input wire logic RESULT_CRC_ERR_IN,
    input wire logic RESULT_TIMEOUT_IN,
    input wire logic RESULT_INVALID_IN,
    output logic [7:0] NOACK_FLAGS_OUT,
    output logic [7:0] CRC_ERR_FLAGS_OUT,
    output logic [7:0] TIMEOUT_FLAGS_OUT,
    output logic [7:0] LIMIT_FLAGS_OUT,
    output logic [7:0] INVALID_FLAGS_OUT,
    output logic [7:0] CRIT_FLAGS_OUT,
    output logic FAULT_OUT,
    output logic [7:0] HIGH_LIMIT_OUT,
    output logic [7:0] LOW_LIMIT_OUT,
    output logic [7:0] CRIT_LIMIT_OUT,
    output logic [7:0] FAN_START_OUT,
    output logic [13:0] RAMP_SPAN_X100_OUT
);

    // ------------------------------------------------------------------
    // State record.
    // ------------------------------------------------------------------
    typedef struct packed {
        smr_poll_e state;
        logic [TICK_CNT_W-1:0] tick_cnt;
        logic [1:0] unit_cnt;
        logic poll_start;
        logic [7:0] rdata;
        logic [7:0] noack_mask;
        logic [7:0] crc_error_mask;
        logic [7:0] timeout_mask;
        logic [7:0] limit_mask;
        logic [7:0] invalid_code_mask;
        logic [7:0] high_limit;
        logic [7:0] low_limit;
        logic [7:0] critical_temp;
        logic [7:0] fan_start;
        logic [3:0] ramp_span_code;
        logic [1:0] poll_period_select;
        logic [13:0] span_x100;
        logic [7:0] noack_flags;
        logic [7:0] crc_flags;
        logic [7:0] timeout_flags;
        logic [7:0] limit_flags;
        logic [7:0] invalid_flags;
        logic [7:0] overtemp_flags;
        logic fault;
    } smr_state_s;

    localparam logic [TICK_CNT_W-1:0] TICK_LAST =
        TICK_CNT_W'(TICK_CYCLES - 1);

    smr_state_s q;
    smr_state_s d;
    logic good_data;
    logic over_high;
    logic under_low;
    logic over_crit;

    // ------------------------------------------------------------------
    // Result classification.
    // ------------------------------------------------------------------

    // A temperature counts only when the transfer finished cleanly.
    assign good_data = !RESULT_NOACK_IN && !RESULT_CRC_ERR_IN &&
                       !RESULT_TIMEOUT_IN && !RESULT_INVALID_IN;
    assign over_high = RESULT_TEMP_IN > q.high_limit;
    assign under_low = $signed(RESULT_TEMP_IN) < $signed(q.low_limit);
    assign over_crit = RESULT_TEMP_IN > q.critical_temp;

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------

    // Register access, loop timing and flag update in one pass.
    always_comb begin
        d = q;
        d.poll_start = 1'b0;
        // Writes land only on writable registers; reserved bits are dropped.
        if (REG_WR_IN) begin
            if (REG_ADDR_IN == ADDR_NOACK_MASK) begin
                d.noack_mask = REG_WDATA_IN;
            end else if (REG_ADDR_IN == ADDR_CRC_MASK) begin
                d.crc_error_mask = REG_WDATA_IN;
            end else if (REG_ADDR_IN == ADDR_TIMEOUT_MASK) begin
                d.timeout_mask = REG_WDATA_IN;
            end else if (REG_ADDR_IN == ADDR_LIMIT_MASK) begin
                d.limit_mask = REG_WDATA_IN;
            end else if (REG_ADDR_IN == ADDR_INVALID_MASK) begin
                d.invalid_code_mask = REG_WDATA_IN;
            end else if (REG_ADDR_IN == ADDR_HIGH_LIMIT) begin
                d.high_limit = REG_WDATA_IN;
            end else if (REG_ADDR_IN == ADDR_LOW_LIMIT) begin
                d.low_limit = REG_WDATA_IN;
            end else if (REG_ADDR_IN == ADDR_CRIT_LIMIT) begin
                d.critical_temp = REG_WDATA_IN;
            end else if (REG_ADDR_IN == ADDR_FAN_START) begin
                d.fan_start = REG_WDATA_IN;
            end else if (REG_ADDR_IN == ADDR_SPAN_INTERVAL) begin
                d.ramp_span_code = REG_WDATA_IN[SPAN_MSB:SPAN_LSB];
                d.poll_period_select =
                    REG_WDATA_IN[INTERVAL_MSB:INTERVAL_LSB];
            end
        end
        // Reads return the current value one cycle later; others give zero.
        if (REG_RD_IN) begin
            if (REG_ADDR_IN == ADDR_CRIT_STATUS) begin
                d.rdata = q.overtemp_flags;
            end else if (REG_ADDR_IN == ADDR_NOACK_MASK) begin
                d.rdata = q.noack_mask;
            end else if (REG_ADDR_IN == ADDR_CRC_MASK) begin
                d.rdata = q.crc_error_mask;
            end else if (REG_ADDR_IN == ADDR_TIMEOUT_MASK) begin
                d.rdata = q.timeout_mask;
            end else if (REG_ADDR_IN == ADDR_LIMIT_MASK) begin
                d.rdata = q.limit_mask;
            end else if (REG_ADDR_IN == ADDR_INVALID_MASK) begin
                d.rdata = q.invalid_code_mask;
            end else if (REG_ADDR_IN == ADDR_HIGH_LIMIT) begin
                d.rdata = q.high_limit;
            end else if (REG_ADDR_IN == ADDR_LOW_LIMIT) begin
                d.rdata = q.low_limit;
            end else if (REG_ADDR_IN == ADDR_CRIT_LIMIT) begin
                d.rdata = q.critical_temp;
            end else if (REG_ADDR_IN == ADDR_FAN_START) begin
                d.rdata = q.fan_start;
            end else if (REG_ADDR_IN == ADDR_SPAN_INTERVAL) begin
                d.rdata = {q.poll_period_select, 2'b00,
                           q.ramp_span_code};
            end else begin
                d.rdata = 8'h00;
            end
        end
        // Loop timer: a start pulse every (select + 1) units of 250 ms.
        case (q.state)
            POLL_IDLE: begin
                d.tick_cnt = '0;
                d.unit_cnt = 2'b00;
                if (POLLER_ENABLE_IN) begin
                    d.state = POLL_RUN;
                    d.poll_start = 1'b1;
                end
            end
            POLL_RUN: begin
                if (!POLLER_ENABLE_IN) begin
                    d.state = POLL_IDLE;
                    d.tick_cnt = '0;
                    d.unit_cnt = 2'b00;
                end else if (q.tick_cnt >= TICK_LAST) begin
                    d.tick_cnt = '0;
                    // A select lowered to or below the unit count ends the current loop at the next unit boundary.
                    if (q.unit_cnt >= q.poll_period_select) begin
                        d.unit_cnt = 2'b00;
                        d.poll_start = 1'b1;
                    end else begin
                        d.unit_cnt = q.unit_cnt + 2'b01;
                    end
                end else begin
                    d.tick_cnt = q.tick_cnt + TICK_CNT_W'(1);
                end
            end
            default: begin
                d.state = POLL_IDLE;
            end
        endcase
        // Each result taken while running and enabled rewrites the flags of its device from that reading.
        if (RESULT_VALID_IN && q.state == POLL_RUN &&
            POLLER_ENABLE_IN) begin
            d.noack_flags[RESULT_DEV_IN] = RESULT_NOACK_IN;
            d.crc_flags[RESULT_DEV_IN] = RESULT_CRC_ERR_IN;
            d.timeout_flags[RESULT_DEV_IN] = RESULT_TIMEOUT_IN;
            d.invalid_flags[RESULT_DEV_IN] = RESULT_INVALID_IN;
            d.limit_flags[RESULT_DEV_IN] =
                good_data && (over_high || under_low);
            d.overtemp_flags[RESULT_DEV_IN] = good_data && over_crit;
        end
        d.span_x100 = smr_span_x100(d.ramp_span_code);
        // Masked flags stay visible but never reach the fault output.
        d.fault = |((d.noack_flags & ~d.noack_mask) |
                    (d.crc_flags & ~d.crc_error_mask) |
                    (d.timeout_flags & ~d.timeout_mask) |
                    (d.limit_flags & ~d.limit_mask) |
                    (d.invalid_flags & ~d.invalid_code_mask));
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------

    // Synchronous reset loads the power-on values.
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            q.state <= POLL_IDLE;
            q.tick_cnt <= '0;
            q.unit_cnt <= 2'b00;
            q.poll_start <= 1'b0;
            q.rdata <= 8'h00;
            q.noack_mask <= RST_STATUS_MASK;
            q.crc_error_mask <= RST_STATUS_MASK;
            q.timeout_mask <= RST_STATUS_MASK;
            q.limit_mask <= RST_STATUS_MASK;
            q.invalid_code_mask <= RST_STATUS_MASK;
            q.high_limit <= RST_HIGH_LIMIT;
            q.low_limit <= RST_LOW_LIMIT;
            q.critical_temp <= RST_CRIT_LIMIT;
            q.fan_start <= RST_FAN_START;
            q.ramp_span_code <= RST_SPAN_INTERVAL[SPAN_MSB:SPAN_LSB];
            q.poll_period_select <=
                RST_SPAN_INTERVAL[INTERVAL_MSB:INTERVAL_LSB];
            q.span_x100 <= smr_span_x100(RST_SPAN_INTERVAL[SPAN_MSB:SPAN_LSB]);
            q.noack_flags <= RST_STATUS_MASK;
            q.crc_flags <= RST_STATUS_MASK;
            q.timeout_flags <= RST_STATUS_MASK;
            q.limit_flags <= RST_STATUS_MASK;
            q.invalid_flags <= RST_STATUS_MASK;
            q.overtemp_flags <= RST_STATUS_MASK;
            q.fault <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------

    // Every output comes straight from the state record.
    assign REG_RDATA_OUT = q.rdata;
    assign POLL_START_OUT = q.poll_start;
    assign NOACK_FLAGS_OUT = q.noack_flags;
    assign CRC_ERR_FLAGS_OUT = q.crc_flags;
    assign TIMEOUT_FLAGS_OUT = q.timeout_flags;
    assign LIMIT_FLAGS_OUT = q.limit_flags;
    assign INVALID_FLAGS_OUT = q.invalid_flags;
    assign CRIT_FLAGS_OUT = q.overtemp_flags;
    assign FAULT_OUT = q.fault;
    assign HIGH_LIMIT_OUT = q.high_limit;
    assign LOW_LIMIT_OUT = q.low_limit;
    assign CRIT_LIMIT_OUT = q.critical_temp;
    assign FAN_START_OUT = q.fan_start;
    assign RAMP_SPAN_X100_OUT = q.span_x100;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------

    // Cycles since the last loop start, and whether the select moved.
    logic [31:0] gap_q;
    logic gap_ok_q;
    always_ff @(posedge CLK_IN) begin
        if (RST_IN || q.poll_start) begin
            gap_q <= 32'h0000_0000;
            gap_ok_q <= !RST_IN && POLLER_ENABLE_IN;
        end else begin
            gap_q <= gap_q + 32'h0000_0001;
            if (d.poll_period_select != q.poll_period_select ||
                !POLLER_ENABLE_IN) begin
                gap_ok_q <= 1'b0;
            end
        end
    end

    a_crit_flag_set: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        RESULT_VALID_IN && q.state == POLL_RUN && POLLER_ENABLE_IN &&
        good_data && over_crit |=> CRIT_FLAGS_OUT[$past(RESULT_DEV_IN)])
        else $error("critical flag not set above limit");

    a_noack_unmasked_fault: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        |(NOACK_FLAGS_OUT & ~q.noack_mask) |-> FAULT_OUT)
        else $error("unmasked no-ack flag gave no fault");

    a_crc_unmasked_fault: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        |(CRC_ERR_FLAGS_OUT & ~q.crc_error_mask) |-> FAULT_OUT)
        else $error("unmasked crc flag gave no fault");

    a_timeout_unmasked_fault: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        |(TIMEOUT_FLAGS_OUT & ~q.timeout_mask) |-> FAULT_OUT)
        else $error("unmasked timeout flag gave no fault");

    a_limit_flag_fault: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        RESULT_VALID_IN && q.state == POLL_RUN && POLLER_ENABLE_IN &&
        good_data && over_high && !q.limit_mask[RESULT_DEV_IN] &&
        !REG_WR_IN |=> LIMIT_FLAGS_OUT[$past(RESULT_DEV_IN)] && FAULT_OUT)
        else $error("out-of-limit reading raised no fault");

    a_invalid_unmasked_fault: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        |(INVALID_FLAGS_OUT & ~q.invalid_code_mask) |-> FAULT_OUT)
        else $error("unmasked invalid flag gave no fault");

    a_reset_values: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        $past(RST_IN) |-> q.noack_mask == 8'h00 && q.limit_mask == 8'h00 &&
        CRIT_FLAGS_OUT == 8'h00 && HIGH_LIMIT_OUT == 8'h7f &&
        LOW_LIMIT_OUT == 8'h81 && CRIT_LIMIT_OUT == 8'h64 &&
        FAN_START_OUT == 8'h5a && RAMP_SPAN_X100_OUT == 14'd3200)
        else $error("power-on values wrong");

    a_fault_needs_cause: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        FAULT_OUT |-> |((NOACK_FLAGS_OUT & ~q.noack_mask) |
                        (CRC_ERR_FLAGS_OUT & ~q.crc_error_mask) |
                        (TIMEOUT_FLAGS_OUT & ~q.timeout_mask) |
                        (LIMIT_FLAGS_OUT & ~q.limit_mask) |
                        (INVALID_FLAGS_OUT & ~q.invalid_code_mask)))
        else $error("fault without an unmasked flag");

    a_loop_period: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        q.poll_start && gap_ok_q && $past(POLLER_ENABLE_IN) |->
        gap_q + 32'h0000_0001 ==
        (32'(q.poll_period_select) + 32'h1) * 32'(TICK_CYCLES))
        else $error("loop period wrong");

    a_disabled_quiet: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        !POLLER_ENABLE_IN ##1 !POLLER_ENABLE_IN |-> !POLL_START_OUT)
        else $error("loop started while disabled");

    a_reserved_read_zero: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        REG_RD_IN && REG_ADDR_IN == ADDR_SPAN_INTERVAL
        |=> REG_RDATA_OUT[5:4] == 2'b00 &&
        REG_RDATA_OUT[3:0] == $past(q.ramp_span_code))
        else $error("span register read wrong");

    c_loop_start: cover property (
        @(posedge CLK_IN) disable iff (RST_IN) POLL_START_OUT);
    c_fault_seen: cover property (
        @(posedge CLK_IN) disable iff (RST_IN) $rose(FAULT_OUT));
    c_crit_seen: cover property (
        @(posedge CLK_IN) disable iff (RST_IN) $rose(|CRIT_FLAGS_OUT));
    c_masked_flag: cover property (
        @(posedge CLK_IN) disable iff (RST_IN)
        |(NOACK_FLAGS_OUT & q.noack_mask) && !FAULT_OUT);

endmodule

// file: sim/smr_sensor_model.sv
// Behavioural model of the polled sensors that return poll results.
`timescale 1ns/10ps

module smr_sensor_model (
    input wire logic clk_in,
    output logic valid_out,
    output logic [2:0] dev_out,
    output logic [7:0] temp_out,
    output logic [3:0] err_out
);
    // Nothing is offered until the first result is sent.
    initial begin
        valid_out = 1'b0;
        dev_out = 3'h0;
        temp_out = 8'h00;
        err_out = 4'h0;
    end

    // Offers one result for one clock; err bits are noack, crc, timeout
    // and invalid. Released lines show the inverse so stale data is seen.
    task automatic send(input logic [2:0] dev, input logic [7:0] temp,
                        input logic [3:0] err);
        @(negedge clk_in);
        valid_out = 1'b1;
        dev_out = dev;
        temp_out = temp;
        err_out = err;
        @(negedge clk_in);
        valid_out = 1'b0;
        dev_out = ~dev;
        temp_out = ~temp;
        err_out = ~err;
    endtask
endmodule

// file: sim/test_smr_regs.sv
// Self-checking bench for the polled-sensor register bank.
`timescale 1ns/10ps

module test_smr_regs;
    localparam int TICKS = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, hi, lo, cr, fs, f_na, f_crc, f_to, f_lim, f_inv, f_cr;
    logic start, fault, rv;
    logic [2:0] rdev;
    logic [7:0] rtemp;
    logic [3:0] rerr;
    logic [13:0] span;
    logic [31:0] fl;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    // Register map, reset contents, span table and mask of each error kind.
    logic [7:0] ra [11] = '{8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'hc0, 8'hc1,
                            8'hc2, 8'hc3, 8'hc6, 8'hc7};
    logic [7:0] r0 [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7f,
                            8'h81, 8'h64, 8'h5a, 8'h0c};
    int sp [16] = '{200, 250, 333, 400, 500, 667, 800, 1000, 1333, 1600,
                    2000, 2667, 3200, 4000, 5333, 8000};
    int mi [4] = '{1, 2, 3, 5};
    assign fl = {f_inv, f_to, f_crc, f_na};

    // Clock of 25 ns period.
    always #12.5 clk = ~clk;

    smr_regs #(.TICK_CYCLES(TICKS)) smr_regs_i (
        .CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WR_IN(wr),
        .REG_WDATA_IN(wdata), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .POLLER_ENABLE_IN(en), .POLL_START_OUT(start),
        .RESULT_VALID_IN(rv), .RESULT_DEV_IN(rdev), .RESULT_TEMP_IN(rtemp),
        .RESULT_NOACK_IN(rerr[0]), .RESULT_CRC_ERR_IN(rerr[1]),
        .RESULT_TIMEOUT_IN(rerr[2]), .RESULT_INVALID_IN(rerr[3]),
        .NOACK_FLAGS_OUT(f_na), .CRC_ERR_FLAGS_OUT(f_crc),
        .TIMEOUT_FLAGS_OUT(f_to), .LIMIT_FLAGS_OUT(f_lim),
        .INVALID_FLAGS_OUT(f_inv), .CRIT_FLAGS_OUT(f_cr), .FAULT_OUT(fault),
        .HIGH_LIMIT_OUT(hi), .LOW_LIMIT_OUT(lo), .CRIT_LIMIT_OUT(cr),
        .FAN_START_OUT(fs), .RAMP_SPAN_X100_OUT(span)
    );
    smr_sensor_model smr_sensor_model_i (
        .clk_in(clk), .valid_out(rv), .dev_out(rdev), .temp_out(rtemp),
        .err_out(rerr)
    );

    // ------------------------------------------------------------------
    // Bus cycles and comparisons.
    // ------------------------------------------------------------------
    task automatic chk8(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk14(input string name, input logic [13:0] exp,
                         input logic [13:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        wdata = ~d;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk8($sformatf("register %h", a), exp, rdata);
    endtask

    task automatic test_done();
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_reset_rw();
        logic [7:0] d;
        logic [7:0] m;
        for (int i = 0; i < 11; i++) begin
            rd_chk(ra[i], r0[i]);
        end
        chk14("span", 14'h0c80, span);
        for (int p = 0; p < 2; p++) begin
            d = (p == 0) ? 8'hff : 8'h00;
            for (int i = 0; i < 11; i++) begin
                // Status reads zero, fan start stays within 0 to 175 C,
                // and the reserved span bits are dropped.
                m = (i == 0) ? 8'h00 : (i == 9) ? 8'haf :
                    (i == 10) ? 8'hcf : 8'hff;
                wr_reg(ra[i], d & ((i == 9) ? 8'haf : 8'hff));
                rd_chk(ra[i], d & m);
            end
            chk8("high limit", d, hi);
            chk8("low limit", d, lo);
            chk8("crit limit", d, cr);
            chk8("fan start", d & 8'haf, fs);
        end
        wr_reg(8'hc4, 8'hff);
        rd_chk(8'hc4, 8'h00);
        for (int i = 1; i < 11; i++) begin
            wr_reg(ra[i], r0[i]);
        end
    endtask

    task automatic t_span();
        for (int c = 0; c < 16; c++) begin
            wr_reg(8'hc7, 8'(c));
            chk14("span", 14'(sp[c]), span);
        end
    endtask

    task automatic t_period(input logic [1:0] sel);
        int k;
        k = 0;
        wr_reg(8'hc7, {sel, 6'h0c});
        en = 1'b1;
        @(negedge clk);
        chk8("first start", 8'h01, {7'h00, start});
        @(negedge clk);
        while (start !== 1'b1 && k < 200) begin
            k++;
            @(negedge clk);
        end
        chk8("period", 8'((sel + 1) * TICKS), 8'(k + 1));
        en = 1'b0;
    endtask

    task automatic t_flags();
        smr_sensor_model_i.send(3'h1, 8'h90, 4'hf);
        chk8("idle", 8'h00, {7'h00, |{fl, f_lim, f_cr}});
        en = 1'b1;
        @(negedge clk);
        smr_sensor_model_i.send(3'h2, 8'h70, 4'h0);
        chk8("crit flags", 8'h04, f_cr);
        rd_chk(8'hbb, 8'h04);
        smr_sensor_model_i.send(3'h2, 8'h20, 4'h0);
        chk8("crit flags", 8'h00, f_cr);
        for (int k = 0; k < 4; k++) begin
            smr_sensor_model_i.send(3'h5, 8'h20, 4'(1 << k));
            chk8("error flag", 8'h20, fl[8*k +: 8]);
            chk8("fault", 8'h01, {7'h00, fault});
            wr_reg(ra[mi[k]], 8'h20);
            @(negedge clk);
            chk8("masked", 8'h00, {7'h00, fault});
            wr_reg(ra[mi[k]], 8'h00);
            smr_sensor_model_i.send(3'h5, 8'h20, 4'h0);
        end
        wr_reg(8'hc1, 8'hff);
        wr_reg(8'hc3, 8'hff);
        smr_sensor_model_i.send(3'h7, 8'h80, 4'h0);
        chk8("low limit", 8'h80, f_lim);
        chk8("fault", 8'h01, {7'h00, fault});
        wr_reg(8'hbf, 8'h80);
        @(negedge clk);
        chk8("masked fault", 8'h00, {7'h00, fault});
        wr_reg(8'hbf, 8'h00);
        wr_reg(8'hc1, 8'h7f);
        smr_sensor_model_i.send(3'h7, 8'h90, 4'h0);
        chk8("high limit", 8'h80, f_lim);
        chk8("fault", 8'h01, {7'h00, fault});
        en = 1'b0;
    endtask

    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            test_done();
        end
    end

    // Main sequence: reset for two cycles, then every scenario.
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_reset_rw();
        t_span();
        for (int s = 0; s < 4; s++) begin
            t_period(2'(s));
        end
        wr_reg(8'hc7, 8'h0c);
        t_flags();
        test_done();
    end
endmodule
